/* File: design/sprb_regbank.sv */
// Supply fault mask, readback pointer and burst include registers with alert output
//
// Notes on behaviour
// (R1) Mask bit at 1 keeps its supply fault from driving the alert output.
// (R2) Masking only gates alert; the fault status bit still sets.
// (R3) Mask bits 6..0 line up with fault status bits; 15..7 read zero.
// (R4) Fault mask resets to all zeros, every fault may alert.
// (R5) Auto readback enable (bit 9) returns pointed register on every access.
// (R6) Header select 0 puts pointer bits 6..0 into read frame bits 30..24.
// (R7) Header select 1 puts ready, alert and four comparator flags there.
// (R8) Host writes 8-bit pointer; next read returns that register.
// (R9) Burst read skips selectable registers whose include bit is 0; resets 0x3FF.
// (R10) Include bits: fault, live, two results, four diagnostics, counter, supply.
// (R11) Registers without include bit are always returned inside a burst.
// (R12) The burst start register is always returned, even if deselected.
// (R13) A burst may start at comparator output, which has no include bit.
// (R14) Supply status bits stay set until written 1 after condition clears.
// (R15) Alert asserts while any unmasked fault bit is set.
// (R16) Reserved bits ignore writes and read as zero.
`timescale 1ns/100ps
`default_nettype none

module sprb_regbank (
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  input  wire logic                              ce,
  input  wire sprb_pkg::sprb_req_t               req,
  output logic      [sprb_pkg::DATA_W-1:0]       rd_data,
  output logic                                   rd_hit,
  input  wire logic [sprb_pkg::FAULT_W-1:0]      supply_fault_raw,
  input  wire logic                              other_alert,
  input  wire logic                              conv_ready,
  input  wire logic [sprb_pkg::DIN_W-1:0]        din_comp,
  output logic                                   alert_n_out,
  output logic                                   alert_n_oe,
  output sprb_pkg::sprb_frame_t                  frame,
  input  wire logic                              burst_start,
  input  wire logic [sprb_pkg::ADDR_W-1:0]       burst_start_addr,
  input  wire logic                              burst_next,
  input  wire logic                              burst_stop,
  output logic      [sprb_pkg::ADDR_W-1:0]       burst_addr,
  output logic                                   burst_active
);

  logic [sprb_pkg::FAULT_W-1:0]  fault_meta_reg, fault_meta_next;
  logic [sprb_pkg::FAULT_W-1:0]  fault_sync_reg, fault_sync_next;
  logic [sprb_pkg::FAULT_W-1:0]  status_reg,     status_next;
  logic [sprb_pkg::FAULT_W-1:0]  mask_reg,       mask_next;
  logic [sprb_pkg::DATA_W-1:0]   cfg_reg,        cfg_next;
  logic [sprb_pkg::BURST_W-1:0]  map_reg,        map_next;
  logic                          alert_reg,      alert_next;
  sprb_pkg::sprb_frame_t         frame_reg,      frame_next;
  logic [sprb_pkg::DATA_W-1:0]   rd_data_reg,    rd_data_next;
  logic                          rd_hit_reg,     rd_hit_next;
  logic [sprb_pkg::FAULT_W-1:0]  w1c;
  logic [sprb_pkg::DATA_W-1:0]   cfg_wmask;

  function automatic logic wr_hit(input sprb_pkg::sprb_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction : wr_hit

  // ------------------------------------------------------------
  // Fault pin synchroniser
  // ------------------------------------------------------------
  // Monitors are analog comparators, so they are retimed before any use
  always_comb begin
    fault_meta_next = supply_fault_raw;
    fault_sync_next = fault_meta_reg;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fault_meta_reg <= '0;
      fault_sync_reg <= '0;
    end else if (ce) begin
      fault_meta_reg <= fault_meta_next;
      fault_sync_reg <= fault_sync_next;
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  assign cfg_wmask = {6'h00, 1'b1, 1'b1, 8'hFF};
  assign w1c = wr_hit(req, sprb_pkg::SUPPLY_STATUS_ADDR) ?
               req.wdata[sprb_pkg::FAULT_W-1:0] : '0;

  always_comb begin
    // Set wins over the clear so a fault still present cannot be wiped
    status_next = (status_reg & ~w1c) | fault_sync_reg;       // see R2 see R14
    mask_next   = mask_reg;
    cfg_next    = cfg_reg;
    map_next    = map_reg;
    if (wr_hit(req, sprb_pkg::FAULT_MASK_ADDR)) begin
      mask_next = req.wdata[sprb_pkg::FAULT_W-1:0];           // see R3 see R16
    end
    if (wr_hit(req, sprb_pkg::READBACK_CFG_ADDR)) begin
      cfg_next = req.wdata & cfg_wmask;                       // see R8 see R16
    end
    if (wr_hit(req, sprb_pkg::BURST_MAP_ADDR)) begin
      map_next = req.wdata[sprb_pkg::BURST_W-1:0];            // see R9 see R16
    end
  end

  always_comb begin
    rd_data_next = rd_data_reg;
    rd_hit_next  = 1'b0;
    if (req.rd) begin
      rd_hit_next = 1'b1;
      case (req.addr)
        sprb_pkg::FAULT_MASK_ADDR:    rd_data_next = {9'h000, mask_reg};   // see R3
        sprb_pkg::READBACK_CFG_ADDR:  rd_data_next = cfg_reg;
        sprb_pkg::BURST_MAP_ADDR:     rd_data_next = {6'h00, map_reg};
        sprb_pkg::SUPPLY_STATUS_ADDR: rd_data_next = {9'h000, status_reg};
        default: begin
          rd_data_next = '0;
          rd_hit_next  = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Alert and readback frame
  // ------------------------------------------------------------
  always_comb begin
    // Open-drain alert: pulled low while any unmasked fault stands
    alert_next = (|(status_next & ~mask_next)) | other_alert; // see R1 see R15
    frame_next.auto_rd_en = cfg_next[sprb_pkg::AUTO_RD_BIT];  // see R5
    frame_next.pointer    = cfg_next[sprb_pkg::PTR_MSB:0];    // see R8
    if (cfg_next[sprb_pkg::HDR_SEL_BIT]) begin
      frame_next.header = {conv_ready, alert_next, din_comp, 1'b0};      // see R7
    end else begin
      frame_next.header = cfg_next[sprb_pkg::HDR_PTR_MSB:0];             // see R6
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_reg  <= sprb_pkg::SUPPLY_STAT_RST[sprb_pkg::FAULT_W-1:0];
      mask_reg    <= sprb_pkg::FAULT_MASK_RST[sprb_pkg::FAULT_W-1:0];    // see R4
      cfg_reg     <= sprb_pkg::READBACK_CFG_RST;
      map_reg     <= sprb_pkg::BURST_MAP_RST[sprb_pkg::BURST_W-1:0];     // see R9
      alert_reg   <= 1'b0;
      frame_reg   <= '0;
      rd_data_reg <= '0;
      rd_hit_reg  <= 1'b0;
    end else if (ce) begin
      status_reg  <= status_next;
      mask_reg    <= mask_next;
      cfg_reg     <= cfg_next;
      map_reg     <= map_next;
      alert_reg   <= alert_next;
      frame_reg   <= frame_next;
      rd_data_reg <= rd_data_next;
      rd_hit_reg  <= rd_hit_next;
    end
  end

  assign rd_data     = rd_data_reg;
  assign rd_hit      = rd_hit_reg;
  assign frame       = frame_reg;
  assign alert_n_out = 1'b0;
  assign alert_n_oe  = ~alert_reg;

  // ------------------------------------------------------------
  // Burst walker
  // ------------------------------------------------------------
  sprb_burst_seq u_burst (
    .sys_clk          (sys_clk),
    .rst              (rst),
    .ce               (ce),
    .include_map      (map_reg),
    .burst_start      (burst_start),
    .burst_start_addr (burst_start_addr),
    .burst_next       (burst_next),
    .burst_stop       (burst_stop),
    .burst_addr       (burst_addr),
    .burst_active     (burst_active)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_mask_blocks_alert: assert property ( // see R1
    @(posedge sys_clk) disable iff (rst)
    ($past(ce) && ((status_reg & ~mask_reg) == '0) && !$past(other_alert)) |-> alert_n_oe)
    else $error("masked fault still drives alert");

  a_unmasked_alerts: assert property ( // see R15
    @(posedge sys_clk) disable iff (rst)
    ((status_reg & ~mask_reg) != '0) |-> !alert_n_oe)
    else $error("unmasked fault did not drive alert");

  a_fault_still_sets: assert property ( // see R2
    @(posedge sys_clk) disable iff (rst)
    (ce && fault_sync_reg != '0) |=> ((status_reg & $past(fault_sync_reg)) == $past(fault_sync_reg)))
    else $error("fault status bit not set");

  a_w1c_clears: assert property ( // see R14
    @(posedge sys_clk) disable iff (rst)
    (ce && w1c != '0) |=> ((status_reg & $past(w1c & ~fault_sync_reg)) == '0))
    else $error("write one did not clear fault status");

  sequence s_mask_write;
    ce && wr_hit(req, sprb_pkg::FAULT_MASK_ADDR);
  endsequence

  sequence s_mask_read;
    ce && req.rd && (req.addr == sprb_pkg::FAULT_MASK_ADDR);
  endsequence

  a_mask_write_field: assert property ( // see R3
    @(posedge sys_clk) disable iff (rst)
    s_mask_write ##1 s_mask_read |=> (rd_data == {9'h000, $past(req.wdata[6:0], 2)}))
    else $error("mask readback wrong");

  a_reset_values: assert property ( // see R4
    @(posedge sys_clk) disable iff (rst)
    $past(rst) |-> (mask_reg == '0 && map_reg == sprb_pkg::BURST_MAP_RST[9:0] && cfg_reg == '0))
    else $error("register reset value wrong");

  a_header_pointer: assert property ( // see R6
    @(posedge sys_clk) disable iff (rst)
    ($past(ce) && !cfg_reg[sprb_pkg::HDR_SEL_BIT]) |-> (frame.header == cfg_reg[6:0]))
    else $error("frame header does not carry pointer");

  a_header_flags: assert property ( // see R7
    @(posedge sys_clk) disable iff (rst)
    ($past(ce) && cfg_reg[sprb_pkg::HDR_SEL_BIT]) |->
      (frame.header == {$past(conv_ready), !alert_n_oe, $past(din_comp), 1'b0}))
    else $error("frame header does not carry flags");

  a_auto_read: assert property ( // see R5
    @(posedge sys_clk) disable iff (rst)
    (ce && wr_hit(req, sprb_pkg::READBACK_CFG_ADDR)) |=>
      (frame.auto_rd_en == $past(req.wdata[9]) && frame.pointer == $past(req.wdata[7:0])))
    else $error("readback enable or pointer not applied");

  a_reserved_cfg_zero: assert property ( // see R16
    @(posedge sys_clk) disable iff (rst)
    (ce && req.rd && req.addr == sprb_pkg::READBACK_CFG_ADDR) |=> (rd_data[15:10] == 6'h00))
    else $error("reserved readback bits not zero");

endmodule : sprb_regbank

`default_nettype wire

/* File: common/sprb_pkg.sv */
// Shared constants and types for the readback, burst and supply-fault mask register bank
package sprb_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned FAULT_W  = 7;
  localparam int unsigned BURST_W  = 10;
  localparam int unsigned HDR_W    = 7;
  localparam int unsigned DIN_W    = 4;

  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] SUPPLY_STATUS_ADDR = 8'h5B;
  localparam logic [7:0] FAULT_MASK_ADDR    = 8'h60;
  localparam logic [7:0] READBACK_CFG_ADDR  = 8'h64;
  localparam logic [7:0] BURST_MAP_ADDR     = 8'h65;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] FAULT_MASK_RST   = 16'h0000;
  localparam logic [15:0] READBACK_CFG_RST = 16'h0000;
  localparam logic [15:0] BURST_MAP_RST    = 16'h03FF;
  localparam logic [15:0] SUPPLY_STAT_RST  = 16'h0000;

  // ------------------------------------------------------------
  // Field positions in the readback pointer register
  // ------------------------------------------------------------
  localparam int unsigned AUTO_RD_BIT  = 9;
  localparam int unsigned HDR_SEL_BIT  = 8;
  localparam int unsigned PTR_MSB      = 7;
  localparam int unsigned HDR_PTR_MSB  = 6;

  // Supply fault bit order: 6 cal memory, 5 output stage, 4 regulator_1v8_fault,
  // 3 analog_5v_rail_fault, 2 digital_rail_fault, 1 negative_rail_fault,
  // 0 positive_rail_fault

  // Addresses of the ten burst-selectable registers, index = include bit
  localparam logic [BURST_W*ADDR_W-1:0] BURST_ADDRS_DEF = {
    8'h5B, 8'h47, 8'h46, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41, 8'h40, 8'h3F};

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sprb_req_t;

  typedef struct packed {
    logic              auto_rd_en;
    logic [HDR_W-1:0]  header;
    logic [ADDR_W-1:0] pointer;
  } sprb_frame_t;

endpackage : sprb_pkg

/* File: design/sprb_burst_seq.sv */
// Burst read address walker that skips deselected registers
`timescale 1ns/100ps
`default_nettype none

module sprb_burst_seq #(
  parameter logic [sprb_pkg::BURST_W*sprb_pkg::ADDR_W-1:0] SEL_ADDRS = sprb_pkg::BURST_ADDRS_DEF
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic [sprb_pkg::BURST_W-1:0]  include_map,
  input  wire logic                          burst_start,
  input  wire logic [sprb_pkg::ADDR_W-1:0]   burst_start_addr,
  input  wire logic                          burst_next,
  input  wire logic                          burst_stop,
  output logic      [sprb_pkg::ADDR_W-1:0]   burst_addr,
  output logic                               burst_active
);

  localparam int unsigned MAX_STEP = sprb_pkg::BURST_W + 1;

  typedef enum logic {SPRB_IDLE, SPRB_RUN} sprb_bstate_t;

  sprb_bstate_t                    state_reg, state_next;
  logic [sprb_pkg::ADDR_W-1:0]     addr_reg, addr_next;
  logic [sprb_pkg::ADDR_W-1:0]     start_reg, start_next;

  // ------------------------------------------------------------
  // Address classification
  // ------------------------------------------------------------
  function automatic logic keep_addr(input logic [sprb_pkg::ADDR_W-1:0] a,
                                     input logic [sprb_pkg::BURST_W-1:0] map);
    logic k;
    k = 1'b1;
    for (int j = 0; j < sprb_pkg::BURST_W; j++) begin
      if (a == SEL_ADDRS[j*sprb_pkg::ADDR_W +: sprb_pkg::ADDR_W]) begin
        k = map[j];                                           // see R9 see R10
      end
    end
    return k;                                                 // see R11
  endfunction : keep_addr

  // Nine selectable registers (0x3F to 0x47) can be skipped in a row at most, so eleven steps always land
  function automatic logic [sprb_pkg::ADDR_W-1:0] next_kept(
      input logic [sprb_pkg::ADDR_W-1:0] cur, input logic [sprb_pkg::BURST_W-1:0] map);
    logic [sprb_pkg::ADDR_W-1:0] res;
    logic [sprb_pkg::ADDR_W-1:0] cand;
    logic                        found;
    res   = cur + 8'h01;
    found = 1'b0;
    for (int i = 1; i <= MAX_STEP; i++) begin
      cand = cur + sprb_pkg::ADDR_W'(i);
      if (!found && keep_addr(cand, map)) begin
        res   = cand;
        found = 1'b1;
      end
    end
    return res;
  endfunction : next_kept

  // ------------------------------------------------------------
  // Walker
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    start_next = start_reg;
    case (state_reg)
      SPRB_IDLE: begin
        if (burst_start) begin
          state_next = SPRB_RUN;
          addr_next  = burst_start_addr;                      // see R12 see R13
          start_next = burst_start_addr;
        end
      end
      SPRB_RUN: begin
        if (burst_stop) begin
          state_next = SPRB_IDLE;
        end else if (burst_next) begin
          addr_next = next_kept(addr_reg, include_map);       // see R9
        end
      end
      default: begin
        state_next = SPRB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= SPRB_IDLE;
      addr_reg  <= 8'h00;
      start_reg <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      start_reg <= start_next;
    end
  end

  assign burst_addr   = addr_reg;
  assign burst_active = (state_reg == SPRB_RUN);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_start_always_returned: assert property ( // see R12
    @(posedge sys_clk) disable iff (rst)
    (ce && !burst_active && burst_start) |=> (burst_active && burst_addr == $past(burst_start_addr)))
    else $error("burst did not begin at its start address");

  a_skip_deselected: assert property ( // see R9
    @(posedge sys_clk) disable iff (rst)
    burst_active |-> (keep_addr(burst_addr, include_map) || burst_addr == start_reg ||
                      $changed(include_map)))
    else $error("burst landed on a deselected register");

  a_unselectable_kept: assert property ( // see R11
    @(posedge sys_clk) disable iff (rst)
    (ce && burst_active && burst_next && !burst_stop &&
     keep_addr(burst_addr + 8'h01, '0)) |=> (burst_addr == $past(burst_addr) + 8'h01))
    else $error("register without include bit was skipped");

endmodule : sprb_burst_seq

`default_nettype wire

/* File: verif/sprb_host_model.sv */
// Behavioural SPI frame decoder side that issues register requests to the bank
`timescale 1ns/100ps
`default_nettype none

module sprb_host_model (
  input  wire logic                      sys_clk,
  output var  sprb_pkg::sprb_req_t       req,
  input  wire logic [sprb_pkg::DATA_W-1:0] rd_data,
  input  wire logic                      rd_hit
);
  initial req = '0;

  // ------------------------------------------------------------
  // Bus release
  // ------------------------------------------------------------
  // Idle address and data flip so stale values are never mistaken for a request
  task automatic release_bus();
    req.wr    = 1'b0;
    req.rd    = 1'b0;
    req.addr  = ~req.addr;
    req.wdata = ~req.wdata;
  endtask : release_bus

  // ------------------------------------------------------------
  // Transfers
  // ------------------------------------------------------------
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    req.wr    = 1'b1;
    req.rd    = 1'b0;
    req.addr  = a;
    req.wdata = d;
    @(negedge sys_clk);
    release_bus();
  endtask : write_reg

  // Write then read in the very next cycle; the read must see the new value
  task automatic write_read(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge sys_clk);
    req.wr    = 1'b1;
    req.rd    = 1'b0;
    req.addr  = a;
    req.wdata = d;
    @(negedge sys_clk);
    req.wr = 1'b0;
    req.rd = 1'b1;
    @(negedge sys_clk);
    q = rd_data;
    release_bus();
  endtask : write_read

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic h);
    @(negedge sys_clk);
    req.rd   = 1'b1;
    req.wr   = 1'b0;
    req.addr = a;
    @(negedge sys_clk);
    d = rd_data;
    h = rd_hit;
    release_bus();
  endtask : read_reg
endmodule : sprb_host_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the supply fault mask, readback and burst register bank
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic                  sys_clk, rst, ce, other_alert, conv_ready;
  logic                  burst_start, burst_next, burst_stop, rd_hit;
  logic                  alert_n_out, alert_n_oe, burst_active;
  logic [6:0]            raw;
  logic [3:0]            din;
  logic [7:0]            bsa, burst_addr;
  logic [15:0]           rd_data;
  sprb_pkg::sprb_req_t   req;
  sprb_pkg::sprb_frame_t frame;
  int                    fails, checks, cycles;

  sprb_regbank u_sprb_regbank (.sys_clk(sys_clk), .rst(rst), .ce(ce), .req(req),
    .rd_data(rd_data), .rd_hit(rd_hit), .supply_fault_raw(raw), .other_alert(other_alert),
    .conv_ready(conv_ready), .din_comp(din), .alert_n_out(alert_n_out),
    .alert_n_oe(alert_n_oe), .frame(frame), .burst_start(burst_start),
    .burst_start_addr(bsa), .burst_next(burst_next), .burst_stop(burst_stop),
    .burst_addr(burst_addr), .burst_active(burst_active));

  sprb_host_model u_sprb_host_model (.sys_clk(sys_clk), .req(req), .rd_data(rd_data),
    .rd_hit(rd_hit));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input logic hexp);
    logic [15:0] d;
    logic        h;
    u_sprb_host_model.read_reg(a, d, h);
    check("rd_data", d, exp);
    check("rd_hit", {15'h0000, h}, {15'h0000, hexp});
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_sprb_host_model.write_reg(a, d);
  endtask : wr

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_n

  // Kind 0 start, 1 next, 2 stop; strobe stands for exactly one cycle
  task automatic bstep(input int kind, input logic [7:0] a, input logic [7:0] exp_a,
                       input logic exp_act);
    @(negedge sys_clk);
    burst_start = (kind == 0);
    burst_next  = (kind == 1);
    burst_stop  = (kind == 2);
    bsa         = a;
    @(negedge sys_clk);
    burst_start = 1'b0;
    burst_next  = 1'b0;
    burst_stop  = 1'b0;
    bsa         = ~a;
    check("burst_active", {15'h0000, burst_active}, {15'h0000, exp_act});
    if (kind != 2) begin
      check("burst_addr", {8'h00, burst_addr}, {8'h00, exp_a});
    end
  endtask : bstep

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check("alert_n_oe", {15'h0000, alert_n_oe}, 16'h0001);
    check("alert_n_out", {15'h0000, alert_n_out}, 16'h0000);
    check("frame", {frame.auto_rd_en, frame.header, frame.pointer}, 16'h0000);
    rd_chk(8'h60, 16'h0000, 1'b1);
    rd_chk(8'h64, 16'h0000, 1'b1);
    rd_chk(8'h65, 16'h03FF, 1'b1);
    rd_chk(8'h5B, 16'h0000, 1'b1);
  endtask : t_reset

  task automatic t_reserved();
    logic [15:0] q;
    wr(8'h60, 16'hFFFF);
    rd_chk(8'h60, 16'h007F, 1'b1);
    wr(8'h64, 16'hFFFF);
    rd_chk(8'h64, 16'h03FF, 1'b1);
    wr(8'h65, 16'hFD55);
    rd_chk(8'h65, 16'h0155, 1'b1);
    rd_chk(8'h61, 16'h0000, 1'b0);
    u_sprb_host_model.write_read(8'h60, 16'hFF55, q);
    check("mask back to back", q, 16'h0055);
    wr(8'h60, 16'h0000);
  endtask : t_reserved

  // Each supply fault against its own mask bit, then sticky clear after removal
  task automatic t_mask();
    logic [15:0] b;
    for (int i = 0; i < 7; i++) begin
      b = 16'h0001 << i;
      wr(8'h60, b);
      raw[i] = 1'b1;
      wait_n(4);
      check("alert_n_oe masked", {15'h0000, alert_n_oe}, 16'h0001);
      rd_chk(8'h5B, b, 1'b1);
      wr(8'h60, 16'h0000);
      wait_n(2);
      check("alert_n_oe unmasked", {15'h0000, alert_n_oe}, 16'h0000);
      wr(8'h5B, b);
      rd_chk(8'h5B, b, 1'b1);
      raw[i] = 1'b0;
      wait_n(3);
      wr(8'h5B, b);
      wait_n(2);
      rd_chk(8'h5B, 16'h0000, 1'b1);
      check("alert_n_oe cleared", {15'h0000, alert_n_oe}, 16'h0001);
    end
    other_alert = 1'b1;
    wait_n(2);
    check("alert_n_oe other", {15'h0000, alert_n_oe}, 16'h0000);
    other_alert = 1'b0;
    wait_n(2);
  endtask : t_mask

  task automatic t_frame();
    conv_ready = 1'b1;
    din        = 4'hA;
    wr(8'h64, 16'h0305);
    wait_n(1);
    check("auto_rd_en", {15'h0000, frame.auto_rd_en}, 16'h0001);
    check("pointer", {8'h00, frame.pointer}, 16'h0005);
    check("header flags", {9'h000, frame.header}, 16'h0054);
    rd_chk(8'h64, 16'h0305, 1'b1);
    wr(8'h64, 16'h00C5);
    wait_n(1);
    check("header pointer", {9'h000, frame.header}, 16'h0045);
    check("auto_rd_off", {15'h0000, frame.auto_rd_en}, 16'h0000);
    check("pointer8", {8'h00, frame.pointer}, 16'h00C5);
    // Clock enable low: the write must not be taken
    ce = 1'b0;
    wr(8'h64, 16'h0001);
    ce = 1'b1;
    rd_chk(8'h64, 16'h00C5, 1'b1);
  endtask : t_frame

  task automatic t_burst();
    logic [7:0] seq [7];
    seq = '{8'h41, 8'h42, 8'h44, 8'h45, 8'h46, 8'h48, 8'h49};
    // Bits 0, 1, 4 and 8 deselected
    wr(8'h65, 16'h02EC);
    bstep(0, 8'h3F, 8'h3F, 1'b1);
    for (int i = 0; i < 7; i++) begin
      bstep(1, 8'h00, seq[i], 1'b1);
    end
    bstep(2, 8'h00, 8'h00, 1'b0);
    wr(8'h65, 16'h03FE);
    bstep(0, 8'h3E, 8'h3E, 1'b1);
    bstep(1, 8'h00, 8'h40, 1'b1);
    bstep(2, 8'h00, 8'h00, 1'b0);
    wr(8'h65, 16'h01FF);
    bstep(0, 8'h5A, 8'h5A, 1'b1);
    bstep(1, 8'h00, 8'h5C, 1'b1);
    bstep(2, 8'h00, 8'h00, 1'b0);
  endtask : t_burst

  // ------------------------------------------------------------
  // Clock, timeout and main sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Whole sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    rst         = 1'b1;
    ce          = 1'b1;
    other_alert = 1'b0;
    conv_ready  = 1'b0;
    din         = 4'h0;
    raw         = 7'h00;
    burst_start = 1'b0;
    burst_next  = 1'b0;
    burst_stop  = 1'b0;
    bsa         = 8'h00;
    wait_n(2);
    rst = 1'b0;
    t_reset();
    t_reserved();
    t_mask();
    t_frame();
    t_burst();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
